/* File: design/master_card_defs.vh */
`ifndef MASTER_CARD_DEFS_VH
`define MASTER_CARD_DEFS_VH

// Register window and register addresses on the processor address bus.
`define WINDOW_BASE        16'he000
`define WINDOW_MASK        16'hffc0
`define CHAN_RANGE_MASK    16'hffe0
`define ADDR_CHAN_MASK_DATA 16'he020
`define ADDR_CHAN_MASK_CTL 16'he021
`define ADDR_TUNING_DATA   16'he022
`define ADDR_TUNING_CTL    16'he023
`define ADDR_LEVEL_DATA    16'he028
`define ADDR_LEVEL_CTL     16'he029
`define ADDR_FILTER_DATA   16'he02a
`define ADDR_FILTER_CTL    16'he02b
`define ADDR_PRIO_STATUS   16'he02c
`define ADDR_RAISE_CPU1    16'he031
`define ADDR_CLEAR_CPU1    16'he032
`define ADDR_RAISE_CPU2    16'he033
`define ADDR_CLEAR_CPU2    16'he034

// Video RAM region on processor 1 cycles.
`define VRAM_REGION_MASK   16'hc000
`define VRAM_REGION_BASE   16'h8000

// Field positions and reset values.
`define LOCKOUT_BIT        3
`define REG_RESET          8'h00
`define CHAN_MASK_RESET    8'h00

// Oscillator divide ratio.
`define OSC_DIVIDE         2

`endif

/* File: design/priority_interrupt_unit.v */
`timescale 1ns/1ps
`default_nettype none
// Eight-level priority encoder with a current-level threshold. Level 7 is highest.
module priority_interrupt_unit (
  input  wire       clk_sys_in,
  input  wire       rst_in,
  input  wire [7:0] request_in,
  input  wire       status_write_in,
  input  wire [3:0] status_data_in,
  output reg        int_n_out,
  output reg  [2:0] level_out
);

  reg [3:0] current_level;
  reg [2:0] next_level;
  reg       next_hit;
  integer   i;

  always @* begin
    next_level = 3'h0;
    next_hit   = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (request_in[i]) begin
        next_level = i[2:0];
        next_hit   = 1'b1;
      end
    end
    // Bit 3 set means all levels enabled; otherwise only levels above the written one.
    if (!current_level[3] && ({1'b0, next_level} <= current_level)) begin
      next_hit = 1'b0;
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      current_level <= 4'h0;
      int_n_out     <= 1'b1;
      level_out     <= 3'h0;
    end else begin
      if (status_write_in) begin
        current_level <= status_data_in;
      end
      int_n_out <= ~next_hit;
      level_out <= next_level;
    end
  end

endmodule
`default_nettype wire

/* File: design/pitch_rate_multiplier.v */
`timescale 1ns/1ps
`default_nettype none
// Divide-by-two of the master oscillator, then a rate multiplier trimmed by the tuning value.
module pitch_rate_multiplier #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys_in,
  input  wire             rst_in,
  input  wire             osc_in,
  input  wire [WIDTH-1:0] tuning_in,
  output reg              half_clock_out,
  output reg              pitch_clock_out
);

  reg             osc_meta;
  reg             osc_sync;
  reg             osc_prev;
  reg [WIDTH-1:0] accum;
  reg [WIDTH:0]   next_accum;

  always @* begin
    // Base rate one half plus a small trim keeps the range of control narrow.
    next_accum = {1'b0, accum} + {2'b01, {(WIDTH-1){1'b0}}} + {{(WIDTH){1'b0}}, 1'b0}
                 + {{(WIDTH-3){1'b0}}, tuning_in[WIDTH-1:WIDTH-4]};
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      osc_meta        <= 1'b0;
      osc_sync        <= 1'b0;
      osc_prev        <= 1'b0;
      half_clock_out  <= 1'b0;
      pitch_clock_out <= 1'b0;
      accum           <= {WIDTH{1'b0}};
    end else begin
      osc_meta <= osc_in;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      pitch_clock_out <= 1'b0;
      if (osc_sync && !osc_prev) begin
        half_clock_out <= ~half_clock_out;
        if (!half_clock_out) begin
          accum           <= next_accum[WIDTH-1:0];
          pitch_clock_out <= next_accum[WIDTH];
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: design/master_card_control.v */
// What this block does
// RULE1: The card answers a 64-byte window of addresses and either processor may access it.
// RULE2: Accesses to the shared channel-card range are decoded into one channel select.
// RULE3: A channel-range write enables every channel whose mask bit is set.
// RULE4: A channel-range read with more than one mask bit set suppresses the channel select.
// RULE5: Processor 1 accesses to the video RAM region assert video RAM disable.
// RULE6: While the lockout bit is set video RAM is disabled and system RAM enabled. The code drives only video_ram_disable_out; it has no system RAM enable.
// RULE7: The tuning port is an output port whose written value drives the master tuning bits.
// RULE8: Channel cards take the eight primary levels; a second priority unit cascades with it.
// RULE9: The cascaded unit supplies keyboard serial, timer and interprocessor interrupts.
// RULE10: A higher-priority interrupt makes the unit's low output set the request latch.
// RULE11: The pending level drives the interrupt address bus, replacing address bits from 1 up.
// RULE12: Writing a new current status clears the processor 1 request latch.
// RULE13: Dedicated addresses raise or clear an interrupt to each processor.
// RULE14: The oscillator is halved and passed through tuning rate multipliers to the cards.
// RULE15: Software holds exactly one mask bit set when it reads from a channel card.
`timescale 1ns/1ps
`default_nettype none
`include "master_card_defs.vh"
module master_card_control #(
  parameter CHANNELS = 8
) (
  input  wire                clk_sys_in,
  input  wire                rst_in,
  input  wire                valid_address_in,
  input  wire                cpu2_cycle_in,
  input  wire                read_in,
  input  wire [15:0]         address_in,
  input  wire [7:0]          write_data_in,
  output reg  [7:0]          read_data_out,
  output reg                 window_select_out,
  output reg                 channel_select_decoded_out,
  output reg  [CHANNELS-1:0] channel_select_out,
  output reg                 video_ram_disable_out,
  output reg  [7:0]          master_tuning_bits_out,
  output reg  [7:0]          level_data_out,
  output reg  [7:0]          filter_select_data_out,
  input  wire [CHANNELS-1:0] channel_irq_in,
  input  wire                keyboard_serial_irq_in,
  input  wire                timer_interrupt_in,
  input  wire                vector_fetch_in,
  output reg                 cpu1_interrupt_request_out,
  output reg                 cpu2_interrupt_request_out,
  output reg  [2:0]          interrupt_address_out,
  output reg  [15:0]         memory_address_out,
  output wire                cascade_int_n_out,
  input  wire                oscillator_in,
  output wire                half_clock_out,
  output wire                channel_pitch_clock_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for asynchronous interrupt sources.
  reg [CHANNELS+1:0] irq_meta;
  reg [CHANNELS+1:0] irq_sync;

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_meta <= {(CHANNELS+2){1'b0}};
      irq_sync <= {(CHANNELS+2){1'b0}};
    end else begin
      irq_meta <= {keyboard_serial_irq_in, timer_interrupt_in, channel_irq_in};
      irq_sync <= irq_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  wire in_window  = valid_address_in && ((address_in & `WINDOW_MASK) == `WINDOW_BASE);
  wire in_channel = valid_address_in && ((address_in & `CHAN_RANGE_MASK) == `WINDOW_BASE);
  wire wr         = in_window && !read_in;
  wire acc        = in_window;

  reg  [7:0] chan_mask;
  reg  [7:0] chan_mask_ctl;
  reg  [7:0] tuning_ctl;
  reg  [7:0] level_ctl;
  reg  [7:0] filter_ctl;
  reg        cpu1_latch;
  reg        ipc_cpu1;
  wire       multi_mask;
  wire       unit_int_n;
  wire [2:0] unit_level;

  // More than one bit set: clear the lowest set bit and see what remains.
  assign multi_mask = |(chan_mask & (chan_mask - 8'h01));

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      chan_mask              <= `CHAN_MASK_RESET;
      chan_mask_ctl          <= `REG_RESET;
      master_tuning_bits_out <= `REG_RESET;
      tuning_ctl             <= `REG_RESET;
      level_data_out         <= `REG_RESET;
      level_ctl              <= `REG_RESET;
      filter_select_data_out <= `REG_RESET;
      filter_ctl             <= `REG_RESET;
    end else if (wr) begin
      case (address_in)
        `ADDR_CHAN_MASK_DATA: chan_mask              <= write_data_in;
        `ADDR_CHAN_MASK_CTL:  chan_mask_ctl          <= write_data_in;
        `ADDR_TUNING_DATA:    master_tuning_bits_out <= write_data_in; // [RULE7]
        `ADDR_TUNING_CTL:     tuning_ctl             <= write_data_in;
        `ADDR_LEVEL_DATA:     level_data_out         <= write_data_in;
        `ADDR_LEVEL_CTL:      level_ctl              <= write_data_in;
        `ADDR_FILTER_DATA:    filter_select_data_out <= write_data_in;
        `ADDR_FILTER_CTL:     filter_ctl             <= write_data_in;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered bus-side outputs for the current cycle.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      window_select_out          <= 1'b0;
      channel_select_decoded_out <= 1'b0;
      channel_select_out         <= {CHANNELS{1'b0}};
      video_ram_disable_out      <= 1'b0;
      read_data_out              <= 8'h00;
    end else begin
      window_select_out          <= acc; // [RULE1]
      channel_select_decoded_out <= in_channel && !(read_in && multi_mask); // [RULE2] [RULE4]
      channel_select_out         <= (in_channel && !(read_in && multi_mask)) ?
                                    chan_mask[CHANNELS-1:0] : {CHANNELS{1'b0}}; // [RULE3] [RULE4]
      video_ram_disable_out      <= chan_mask_ctl[`LOCKOUT_BIT] || // [RULE6]
                                    (valid_address_in && !cpu2_cycle_in &&
                                     ((address_in & `VRAM_REGION_MASK) == `VRAM_REGION_BASE)); // [RULE5]
      read_data_out <= 8'h00;
      if (acc && read_in) begin
        case (address_in)
          `ADDR_CHAN_MASK_DATA: read_data_out <= chan_mask;
          `ADDR_CHAN_MASK_CTL:  read_data_out <= chan_mask_ctl;
          `ADDR_TUNING_DATA:    read_data_out <= master_tuning_bits_out;
          `ADDR_TUNING_CTL:     read_data_out <= tuning_ctl;
          `ADDR_LEVEL_DATA:     read_data_out <= level_data_out;
          `ADDR_LEVEL_CTL:      read_data_out <= level_ctl;
          `ADDR_FILTER_DATA:    read_data_out <= filter_select_data_out;
          `ADDR_FILTER_CTL:     read_data_out <= filter_ctl;
          `ADDR_PRIO_STATUS:    read_data_out <= {4'h0, cpu1_latch, unit_level};
          default:              read_data_out <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interprocessor interrupts; an access of either direction counts.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      ipc_cpu1                   <= 1'b0;
      cpu2_interrupt_request_out <= 1'b0;
    end else if (acc) begin
      if (address_in == `ADDR_RAISE_CPU1) begin
        ipc_cpu1 <= 1'b1; // [RULE13]
      end else if (address_in == `ADDR_CLEAR_CPU1) begin
        ipc_cpu1 <= 1'b0; // [RULE13]
      end
      if (address_in == `ADDR_RAISE_CPU2) begin
        cpu2_interrupt_request_out <= 1'b1; // [RULE13]
      end else if (address_in == `ADDR_CLEAR_CPU2) begin
        cpu2_interrupt_request_out <= 1'b0; // [RULE13]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascaded priority unit: levels 7..5 are interprocessor, timer, keyboard.
  // Level 0 carries the cascade from the primary channel requests; levels 4..1 are tied low.
  wire       status_wr = wr && (address_in == `ADDR_PRIO_STATUS);
  wire       primary_any = |irq_sync[CHANNELS-1:0]; // [RULE8]
  wire [7:0] unit_req = {ipc_cpu1, irq_sync[CHANNELS], irq_sync[CHANNELS+1],
                         4'h0, primary_any}; // [RULE9]
  reg  [2:0] primary_level;
  integer    k;

  always @* begin
    primary_level = 3'h0;
    for (k = 0; k < CHANNELS; k = k + 1) begin
      if (irq_sync[k]) begin
        primary_level = k[2:0];
      end
    end
  end

  priority_interrupt_unit u_prio (
    .clk_sys_in      (clk_sys_in),
    .rst_in          (rst_in),
    .request_in      (unit_req),
    .status_write_in (status_wr),
    .status_data_in  (write_data_in[3:0]),
    .int_n_out       (unit_int_n),
    .level_out       (unit_level)
  );

  assign cascade_int_n_out = unit_int_n;

  // The latch holds the request even if the source drops; only a status write releases it.
  // A new interrupt in the same cycle as the write wins, so none is lost.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      cpu1_latch <= 1'b0;
    end else if (!unit_int_n) begin
      cpu1_latch <= 1'b1; // [RULE10]
    end else if (status_wr) begin
      cpu1_latch <= 1'b0; // [RULE12]
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      cpu1_interrupt_request_out <= 1'b0;
      interrupt_address_out      <= 3'h0;
      memory_address_out         <= 16'h0000;
    end else begin
      cpu1_interrupt_request_out <= cpu1_latch;
      interrupt_address_out      <= (unit_level == 3'h0) ? primary_level : unit_level; // [RULE11]
      memory_address_out         <= vector_fetch_in ?
                                    {address_in[15:4], interrupt_address_out, address_in[0]} :
                                    address_in; // [RULE11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master pitch path.
  pitch_rate_multiplier #(
    .WIDTH (8)
  ) u_pitch (
    .clk_sys_in      (clk_sys_in),
    .rst_in          (rst_in),
    .osc_in          (oscillator_in),
    .tuning_in       (master_tuning_bits_out),
    .half_clock_out  (half_clock_out),
    .pitch_clock_out (channel_pitch_clock_out)
  ); // [RULE14]

endmodule
`default_nettype wire

/* File: tb/card_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module card_side_model (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] raise_in,
  output logic            osc_out,
  output logic [7:0]      irq_out
);
  // The crystal runs free and unrelated to the system clock, so its edges drift through every phase.
  initial begin
    osc_out = 1'b0;
    forever #14.58 osc_out = ~osc_out;
  end
  // Each card holds its request until it is told to drop it.
  always @(posedge clk_sys_in) irq_out <= raise_in;
endmodule
`default_nettype wire

/* File: tb/master_card_control_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module master_card_control_checker #(
  parameter CHANNELS = 8
) (
  input wire logic                clk_sys_in,
  input wire logic                rst_in,
  input wire logic                valid_address_in,
  input wire logic                cpu2_cycle_in,
  input wire logic                read_in,
  input wire logic [15:0]         address_in,
  input wire logic [7:0]          write_data_in,
  input wire logic                vector_fetch_in,
  input wire logic                window_select_out,
  input wire logic                channel_select_decoded_out,
  input wire logic [CHANNELS-1:0] channel_select_out,
  input wire logic                video_ram_disable_out,
  input wire logic [7:0]          master_tuning_bits_out,
  input wire logic                cpu1_interrupt_request_out,
  input wire logic                cpu2_interrupt_request_out,
  input wire logic [2:0]          interrupt_address_out,
  input wire logic [15:0]         memory_address_out,
  input wire logic                cascade_int_n_out,
  input wire logic                channel_pitch_clock_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire wr = valid_address_in && !read_in;
  ////////////////////////////////////////////////////////////////
  property p_win; 1'b1 |=> window_select_out == $past(valid_address_in && address_in[15:6] == 10'h380); endproperty
  a_win: assert property (p_win) else $error("window select wrong");
  property p_chw; wr && address_in[15:5] == 11'h700 |=> channel_select_decoded_out; endproperty
  a_chw: assert property (p_chw) else $error("channel write not selected");
  property p_chr; channel_select_decoded_out && $past(read_in) |-> $countones(channel_select_out) <= 1; endproperty
  a_chr: assert property (p_chr) else $error("multi channel read");
  property p_vr; valid_address_in && !cpu2_cycle_in && address_in[15:14] == 2'b10 |=>
    video_ram_disable_out; endproperty
  a_vr: assert property (p_vr) else $error("video ram not disabled");
  property p_tun; wr && address_in == 16'he022 |=> master_tuning_bits_out == $past(write_data_in); endproperty
  a_tun: assert property (p_tun) else $error("tuning bits wrong");
  property p_irq; $fell(cascade_int_n_out) |-> ##[1:2] cpu1_interrupt_request_out; endproperty
  a_irq: assert property (p_irq) else $error("request latch not set");
  property p_vec; vector_fetch_in ##1 $stable(interrupt_address_out) |->
    memory_address_out[3:1] == interrupt_address_out; endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_c2s; valid_address_in && address_in == 16'he033 |=> cpu2_interrupt_request_out; endproperty
  a_c2s: assert property (p_c2s) else $error("cpu2 interrupt not raised");
  property p_c2c; valid_address_in && address_in == 16'he034 |=> !cpu2_interrupt_request_out; endproperty
  a_c2c: assert property (p_c2c) else $error("cpu2 interrupt not cleared");
  property p_pit; channel_pitch_clock_out |=> !channel_pitch_clock_out; endproperty
  a_pit: assert property (p_pit) else $error("pitch pulse too long");
endmodule
bind master_card_control master_card_control_checker #(.CHANNELS(CHANNELS)) u_checker (.*);
`default_nettype wire

/* File: tb/master_card_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module master_card_control_tb;
  logic        clk, rst, v, c2, rd, vf, kbd, tmr, arm, take;
  logic [15:0] a;
  logic [7:0]  d, raise, r, tv;
  logic [19:0] q[$];
  logic [19:0] e;
  wire  [7:0]  rdat, cs, tun, lvl, flt, irq;
  wire  [15:0] ma;
  wire  [2:0]  ia;
  wire         win, csd, vrd, i1, i2, cin, hc, pc, osc;
  int          mismatches, n_compared, seed, nh, np, k;
  logic [15:0] regs [3] = '{16'he022, 16'he028, 16'he02a};
  string       nm [13] = '{"read_data", "window", "chan_decoded", "chan_select", "vram_disable", "tuning",
                           "level", "filter", "cpu1_req", "cpu2_req", "int_level", "mem_address",
                           "cascade_int_n"};
  master_card_control #(.CHANNELS(8)) DUT (
    .clk_sys_in(clk), .rst_in(rst), .valid_address_in(v), .cpu2_cycle_in(c2), .read_in(rd),
    .address_in(a), .write_data_in(d), .read_data_out(rdat), .window_select_out(win),
    .channel_select_decoded_out(csd), .channel_select_out(cs), .video_ram_disable_out(vrd),
    .master_tuning_bits_out(tun), .level_data_out(lvl), .filter_select_data_out(flt),
    .channel_irq_in(irq), .keyboard_serial_irq_in(kbd), .timer_interrupt_in(tmr),
    .vector_fetch_in(vf), .cpu1_interrupt_request_out(i1), .cpu2_interrupt_request_out(i2),
    .interrupt_address_out(ia), .memory_address_out(ma), .cascade_int_n_out(cin),
    .oscillator_in(osc), .half_clock_out(hc), .channel_pitch_clock_out(pc));
  card_side_model partner (.clk_sys_in(clk), .raise_in(raise), .osc_out(osc), .irq_out(irq));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      4'd0: obs = {8'h00, rdat};
      4'd1: obs = {15'h0000, win};
      4'd2: obs = {15'h0000, csd};
      4'd3: obs = {8'h00, cs};
      4'd4: obs = {15'h0000, vrd};
      4'd5: obs = {8'h00, tun};
      4'd6: obs = {8'h00, lvl};
      4'd7: obs = {8'h00, flt};
      4'd8: obs = {15'h0000, i1};
      4'd9: obs = {15'h0000, i2};
      4'd10: obs = {13'h0000, ia};
      4'd11: obs = ma;
      default: obs = {15'h0000, cin};
    endcase
  endfunction
  // Outputs are registered at the taking edge itself, so they are judged at the falling edge that follows it.
  always @(posedge clk) take <= arm;
  always @(negedge clk) if (take) begin
    e = q.pop_front();
    n_compared++;
    if (obs(e[19:16]) !== e[15:0]) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm[e[19:16]], e[15:0], obs(e[19:16]));
    end
  end
  always @(hc) nh++;
  always @(posedge pc) np++;
  ////////////////////////////////////////////////////////////////
  task automatic acc(input logic [2:0] m, input logic [15:0] aa, input logic [7:0] dd, input logic [3:0] s,
                     input logic [15:0] ex);
    {v, c2, rd} <= m;
    a <= aa;
    d <= dd;
    arm <= 1'b1;
    q.push_back({s, ex});
    @(posedge clk);
    #1;
  endtask
  task automatic idle(input int n);
    v <= 1'b0;
    arm <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic see(input logic [2:0] lv);
    for (int j = 0; j < 20 && i1 !== 1'b1; j++) begin
      @(posedge clk);
      #1;
    end
    acc(3'b001, 16'h0000, 8'h00, 4'd8, 16'h0001);
    acc(3'b001, 16'h0000, 8'h00, 4'd10, {13'h0000, lv});
    acc(3'b001, 16'h0000, 8'h00, 4'd12, 16'h0000);
    idle(1);
  endtask
  task summarize;
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    seed = 6192;
    {rst, v, c2, rd, vf, kbd, tmr, arm} = 8'h80;
    a = 16'h0000;
    d = 8'h00;
    raise = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    acc(3'b101, 16'he022, 8'h00, 4'd0, 16'h0000);
    for (k = 0; k < 3; k++) begin
      r = $random(seed);
      if (k == 0) tv = r;
      acc(3'b100, regs[k], r, 4'(5 + k), {8'h00, r});
      acc(3'b111, regs[k], 8'h00, 4'd0, {8'h00, r});
    end
    acc(3'b111, 16'he035, 8'h00, 4'd0, 16'h0000);
    acc(3'b101, 16'h1234, 8'h00, 4'd1, 16'h0000);
    acc(3'b100, 16'he020, 8'h05, 4'd1, 16'h0001);
    acc(3'b100, 16'he007, 8'h11, 4'd3, 16'h0005);
    acc(3'b101, 16'he007, 8'h00, 4'd2, 16'h0000);
    acc(3'b100, 16'he020, 8'h04, 4'd1, 16'h0001);
    acc(3'b111, 16'he01f, 8'h00, 4'd3, 16'h0004);
    acc(3'b101, 16'h9abc, 8'h00, 4'd4, 16'h0001);
    acc(3'b101, 16'hbfff, 8'h00, 4'd4, 16'h0001);
    acc(3'b101, 16'hc000, 8'h00, 4'd4, 16'h0000);
    acc(3'b111, 16'h8000, 8'h00, 4'd4, 16'h0000);
    acc(3'b100, 16'he021, 8'h08, 4'd4, 16'h0000);
    idle(1);
    acc(3'b111, 16'h0000, 8'h00, 4'd4, 16'h0001);
    acc(3'b100, 16'he021, 8'h00, 4'd4, 16'h0001);
    idle(1);
    acc(3'b111, 16'h8000, 8'h00, 4'd4, 16'h0000);
    idle(1);
    tmr = 1'b1;
    see(3'd6);
    vf = 1'b1;
    acc(3'b101, 16'hfff0, 8'h00, 4'd11, 16'hfffc);
    vf = 1'b0;
    acc(3'b101, 16'h1236, 8'h00, 4'd11, 16'h1236);
    tmr = 1'b0;
    idle(6);
    acc(3'b001, 16'h0000, 8'h00, 4'd8, 16'h0001);
    acc(3'b100, 16'he02c, 8'h00, 4'd1, 16'h0001);
    idle(3);
    acc(3'b001, 16'h0000, 8'h00, 4'd8, 16'h0000);
    acc(3'b100, 16'he031, 8'h00, 4'd1, 16'h0001);
    idle(1);
    see(3'd7);
    acc(3'b100, 16'he032, 8'h00, 4'd1, 16'h0001);
    idle(6);
    acc(3'b100, 16'he02c, 8'h08, 4'd1, 16'h0001);
    idle(3);
    acc(3'b001, 16'h0000, 8'h00, 4'd8, 16'h0000);
    idle(1);
    raise = 8'h08;
    see(3'd3);
    kbd = 1'b1;
    idle(6);
    see(3'd5);
    acc(3'b100, 16'he033, 8'h00, 4'd9, 16'h0001);
    acc(3'b100, 16'he034, 8'h00, 4'd9, 16'h0000);
    idle(1);
    nh = 0;
    np = 0;
    repeat (1000) @(posedge clk);
    #1;
    n_compared += 2;
    if (nh < 272 || nh > 277) begin
      mismatches++;
      $display("mismatch half_clock expected 274 seen %0d", nh);
    end
    // Each half-clock rising edge adds one half plus the top tuning nibble over 256; phase costs a pulse or two.
    k = (nh / 2) * (128 + tv[7:4]) / 256;
    if (np < k - 2 || np > k + 2) begin
      mismatches++;
      $display("mismatch pitch_pulses expected %0d seen %0d", k, np);
    end
    idle(2);
    summarize();
  end
endmodule
`default_nettype wire
